/* File: design/wcsa_pkg.sv */
package wcsa_pkg;
	// store geometry
	localparam int WCSA_UWORD_W = 80;
	localparam int WCSA_DATA_W = 16;
	localparam int WCSA_RAM_DEPTH = 1024;
	localparam int WCSA_RAM_AW = 10;
	localparam int WCSA_UADDR_W = 11;
	localparam int WCSA_GROUP_W = 3;
	localparam int WCSA_SHIFT_W = 4;
	localparam logic [WCSA_GROUP_W-1:0] WCSA_GROUP_HIGH = 3'h4;
	localparam int WCSA_HIGH_LSB = 64;
	// stack address fields
	localparam int WCSA_STK_GRP_HI = 14;
	localparam int WCSA_STK_GRP_LO_MSB = 2;
	localparam int WCSA_STK_GRP_LO_LSB = 1;
	localparam int WCSA_STK_LOC_MSB = 12;
	localparam int WCSA_STK_LOC_LSB = 3;
	// control address space
	localparam logic [WCSA_UADDR_W-1:0] WCSA_PROM_BASE = 11'h100;
	localparam logic [WCSA_UADDR_W-1:0] WCSA_PROM_LIMIT = 11'h200;
	localparam logic [WCSA_UADDR_W-1:0] WCSA_RAM_BASE = 11'h400;
	// timing
	localparam int WCSA_CLK_NS = 40;
	localparam int WCSA_WRITE_NS = 100;
	localparam int WCSA_PHASE2_NS = 200;
	localparam int WCSA_LONG_NS = 300;
	// least time rounds up, longest time rounds down
	localparam int WCSA_WRITE_CYC = (WCSA_WRITE_NS + WCSA_CLK_NS - 1) / WCSA_CLK_NS;
	localparam int WCSA_PHASE2_CYC = WCSA_PHASE2_NS / WCSA_CLK_NS;
	localparam int WCSA_LONG_CYC = WCSA_LONG_NS / WCSA_CLK_NS;
	localparam int WCSA_CNT_W = 4;

	typedef enum logic [1:0] {
		WCSA_IDLE = 2'b00,
		WCSA_WRITE = 2'b01,
		WCSA_READ = 2'b10,
		WCSA_TAIL = 2'b11
	} wcsa_state_e;

	// groups 5..7 map to no slice of the store
	function automatic logic wcsa_group_valid(input logic [WCSA_GROUP_W-1:0] g);
		wcsa_group_valid = (g <= WCSA_GROUP_HIGH);
	endfunction : wcsa_group_valid

	// bit offset of a 16-bit slice inside a microword
	function automatic int wcsa_slice_lsb(input logic [WCSA_GROUP_W-1:0] g);
		if (g == WCSA_GROUP_HIGH) begin
			wcsa_slice_lsb = WCSA_HIGH_LSB;
		end else begin
			wcsa_slice_lsb = int'(g) * WCSA_DATA_W;
		end
	endfunction : wcsa_slice_lsb
endpackage : wcsa_pkg

/* File: design/wcsa_store.sv */
`timescale 1ns/10ps
module wcsa_store
	import wcsa_pkg::*;
#(
	parameter int DEPTH = WCSA_RAM_DEPTH,
	parameter int AW = WCSA_RAM_AW
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [WCSA_GROUP_W-1:0] wgroup,
	input wire logic [WCSA_DATA_W-1:0] wdata,
	input wire logic [AW-1:0] fetch_addr,
	output logic [WCSA_UWORD_W-1:0] fetch_word,
	input wire logic [AW-1:0] data_addr,
	output logic [WCSA_UWORD_W-1:0] data_word
);
	// one array serves both views; the data view only writes a 16-bit slice
	logic [WCSA_UWORD_W-1:0] mem [0:DEPTH-1];

	// slice write, invalid groups dropped
	always_ff @(posedge clk) begin
		if (we && wcsa_group_valid(wgroup)) begin
			mem[waddr][wcsa_slice_lsb(wgroup) +: WCSA_DATA_W] <= wdata;
		end
	end

	// asynchronous read ports, registered by the sequencer
	assign fetch_word = mem[fetch_addr];
	assign data_word = mem[data_addr];
endmodule : wcsa_store

/* File: design/wcsa_access.sv */
`timescale 1ns/10ps
module wcsa_access
	import wcsa_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic instr_start,
	input wire logic long_three_phase_cycle,
	input wire logic store_write_decoded,
	input wire logic store_read_decoded,
	input wire logic unused_opcode,
	input wire logic [WCSA_DATA_W-1:0] instr_word,
	input wire logic [WCSA_UADDR_W-1:0] next_address_lines,
	input wire logic [WCSA_DATA_W-1:0] stack_top,
	input wire logic [WCSA_DATA_W-1:0] processor_data_mux,
	input wire logic [WCSA_SHIFT_W-1:0] shift_count,
	input wire logic [WCSA_SHIFT_W-1:0] left_mask,
	input wire logic [WCSA_SHIFT_W-1:0] right_mask,
	output logic [WCSA_UADDR_W-1:0] microaddress,
	output logic microaddress_select_mux,
	output logic prom_select,
	output logic [WCSA_UWORD_W-1:0] ram_microword,
	output logic ram_write_strobe,
	output logic second_phase_pulse,
	output logic third_phase_pulse,
	output logic [WCSA_DATA_W-1:0] reg_data_bus,
	output logic data_hold_load,
	output logic [WCSA_DATA_W-1:0] trap_instr,
	output logic trap_load
);
	wcsa_state_e state_reg, state_next;
	logic [WCSA_CNT_W-1:0] cnt_reg, cnt_next;
	logic stk_sel_reg, stk_sel_next;
	logic we_reg, we_next, hold_reg, hold_next;
	logic ph2_reg, ph2_next, ph3_reg, ph3_next;
	logic [WCSA_DATA_W-1:0] rdbus_reg, rdbus_next;
	logic [WCSA_DATA_W-1:0] wdata_reg, wdata_next;
	logic [WCSA_RAM_AW-1:0] waddr_reg, waddr_next;
	logic [WCSA_GROUP_W-1:0] wgrp_reg, wgrp_next;
	logic [WCSA_UADDR_W-1:0] uaddr_reg, uaddr_next;
	logic prom_reg, prom_next;
	logic [WCSA_UWORD_W-1:0] uword_reg, uword_next;
	logic [WCSA_DATA_W-1:0] trap_reg, trap_next;
	logic trap_ld_reg, trap_ld_next;
	logic [WCSA_GROUP_W-1:0] stk_group;
	logic [WCSA_RAM_AW-1:0] stk_loc;
	logic [WCSA_UWORD_W-1:0] fetch_word, data_word;
	logic [WCSA_DATA_W-1:0] slice;

	// rotate right then blank lmask bits from the left, rmask bits from the right
	function automatic logic [WCSA_DATA_W-1:0] shift_mask(input logic [WCSA_DATA_W-1:0] d,
		input logic [WCSA_SHIFT_W-1:0] sh, input logic [WCSA_SHIFT_W-1:0] lm,
		input logic [WCSA_SHIFT_W-1:0] rm);
		logic [2*WCSA_DATA_W-1:0] dd;
		logic [WCSA_DATA_W-1:0] r, lmsk, rmsk;
		dd = {d, d} >> sh;
		r = dd[WCSA_DATA_W-1:0];
		lmsk = {WCSA_DATA_W{1'b1}} >> lm;
		rmsk = {WCSA_DATA_W{1'b1}} << rm;
		shift_mask = r & lmsk & rmsk;
	endfunction : shift_mask
	// group select and location; low byte bit ignored, whole word moved
	assign stk_group = {stack_top[WCSA_STK_GRP_HI],
		stack_top[WCSA_STK_GRP_LO_MSB:WCSA_STK_GRP_LO_LSB]};
	assign stk_loc = stack_top[WCSA_STK_LOC_MSB:WCSA_STK_LOC_LSB];
	// groups 0..3 are the low 64 bits; data comes only from RAM
	always_comb begin
		slice = '0;
		if (wcsa_group_valid(stk_group)) begin
			slice = data_word[wcsa_slice_lsb(stk_group) +: WCSA_DATA_W];
		end
	end
	// one array, microword fetch view and 16-bit data view
	wcsa_store #(
		.DEPTH(WCSA_RAM_DEPTH),
		.AW(WCSA_RAM_AW)
	) u_store (
		.clk(clk),
		.we(we_reg),
		.waddr(waddr_reg),
		.wgroup(wgrp_reg),
		.wdata(wdata_reg),
		.fetch_addr(uaddr_reg[WCSA_RAM_AW-1:0]),
		.fetch_word(fetch_word),
		.data_addr(stk_loc),
		.data_word(data_word)
	);
	// access sequencer and long-cycle timer; a store op always runs the long cycle
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		stk_sel_next = stk_sel_reg;
		we_next = 1'b0;
		ph2_next = 1'b0;
		ph3_next = 1'b0;
		hold_next = 1'b0;
		rdbus_next = rdbus_reg;
		wdata_next = wdata_reg;
		waddr_next = waddr_reg;
		wgrp_next = wgrp_reg;
		case (state_reg)
			WCSA_IDLE: begin
				if (instr_start && (store_write_decoded || store_read_decoded ||
					long_three_phase_cycle)) begin
					cnt_next = WCSA_CNT_W'(1);
					stk_sel_next = store_write_decoded || store_read_decoded;
					if (store_write_decoded) begin
						state_next = WCSA_WRITE;
					end else if (store_read_decoded) begin
						state_next = WCSA_READ;
					end else begin
						state_next = WCSA_TAIL;
					end
				end
			end
			WCSA_WRITE, WCSA_READ, WCSA_TAIL: begin
				cnt_next = cnt_reg + WCSA_CNT_W'(1);
				// write strobe 100 ns after start
				if (state_reg == WCSA_WRITE && cnt_reg == WCSA_CNT_W'(WCSA_WRITE_CYC - 1)) begin
					// strobe only in a decoded write
					we_next = 1'b1;
					// write data from processor data mux
					wdata_next = processor_data_mux;
					waddr_next = stk_loc;
					wgrp_next = stk_group;
				end
				// shifted and masked word on register data bus
				if (state_reg == WCSA_READ) begin
					rdbus_next = shift_mask(slice, shift_count, left_mask, right_mask);
				end
				if (cnt_reg == WCSA_CNT_W'(WCSA_PHASE2_CYC - 1)) begin
					ph2_next = 1'b1;
					// data holder loads at phase two
					hold_next = (state_reg == WCSA_READ);
					// release mux back to next address lines
					stk_sel_next = 1'b0;
					state_next = WCSA_TAIL;
				end
				// phase three pulse ends the 300 ns cycle
				if (cnt_reg == WCSA_CNT_W'(WCSA_LONG_CYC - 1)) begin
					ph3_next = 1'b1;
					state_next = WCSA_IDLE;
					cnt_next = '0;
				end
			end
			default: begin
				state_next = WCSA_IDLE;
				cnt_next = '0;
				stk_sel_next = 1'b0;
			end
		endcase
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= WCSA_IDLE;
			cnt_reg <= '0;
			stk_sel_reg <= 1'b0;
			we_reg <= 1'b0;
			ph2_reg <= 1'b0;
			ph3_reg <= 1'b0;
			hold_reg <= 1'b0;
			rdbus_reg <= '0;
			wdata_reg <= '0;
			waddr_reg <= '0;
			wgrp_reg <= '0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			stk_sel_reg <= stk_sel_next;
			we_reg <= we_next;
			ph2_reg <= ph2_next;
			ph3_reg <= ph3_next;
			hold_reg <= hold_next;
			rdbus_reg <= rdbus_next;
			wdata_reg <= wdata_next;
			waddr_reg <= waddr_next;
			wgrp_reg <= wgrp_next;
		end
	end
	// microaddress mux, PROM enable, RAM fetch and opcode trap
	always_comb begin
		uaddr_next = next_address_lines;
		trap_next = trap_reg;
		trap_ld_next = 1'b0;
		if (unused_opcode) begin
			uaddr_next = WCSA_PROM_BASE;
			// causing instruction to register 13, B and IR
			trap_next = instr_word;
			trap_ld_next = 1'b1;
		end else if (stk_sel_next) begin
			// stack location into the RAM part of the space
			uaddr_next = WCSA_RAM_BASE | WCSA_UADDR_W'(stk_loc);
		end
		// PROM enabled from 256 up to 511, except while the stack drives
		prom_next = !stk_sel_next && uaddr_next >= WCSA_PROM_BASE &&
			uaddr_next < WCSA_PROM_LIMIT;
		// only the upper 1024 words come from the RAM array
		uword_next = '0;
		if (uaddr_reg >= WCSA_RAM_BASE) begin
			uword_next = fetch_word;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			uaddr_reg <= '0;
			prom_reg <= 1'b0;
			uword_reg <= '0;
			trap_reg <= '0;
			trap_ld_reg <= 1'b0;
		end else begin
			uaddr_reg <= uaddr_next;
			prom_reg <= prom_next;
			uword_reg <= uword_next;
			trap_reg <= trap_next;
			trap_ld_reg <= trap_ld_next;
		end
	end
	// every output straight from its flip-flop
	assign microaddress = uaddr_reg;
	assign microaddress_select_mux = stk_sel_reg;
	assign prom_select = prom_reg;
	assign ram_microword = uword_reg;
	assign ram_write_strobe = we_reg;
	assign second_phase_pulse = ph2_reg;
	assign third_phase_pulse = ph3_reg;
	assign reg_data_bus = rdbus_reg;
	assign data_hold_load = hold_reg;
	assign trap_instr = trap_reg;
	assign trap_load = trap_ld_reg;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_wr_start;
		instr_start && state_reg == WCSA_IDLE && store_write_decoded;
	endsequence
	sequence s_op_start;
		instr_start && state_reg == WCSA_IDLE && (store_write_decoded || store_read_decoded);
	endsequence
	property p_write_time;
		s_wr_start |-> !ram_write_strobe [*3] ##1 ram_write_strobe ##1 !ram_write_strobe;
	endproperty
	a_write_time: assert property (p_write_time) else $error("write strobe mistimed");
	property p_strobe_only_write;
		ram_write_strobe |-> $past(state_reg) == WCSA_WRITE;
	endproperty
	a_strobe_only_write: assert property (p_strobe_only_write) else $error("stray strobe");
	property p_mux_on;
		s_op_start |=> microaddress_select_mux && !prom_select;
	endproperty
	a_mux_on: assert property (p_mux_on) else $error("mux not on stack");
	property p_mux_off_ph2;
		s_op_start |-> ##5 second_phase_pulse && !microaddress_select_mux;
	endproperty
	a_mux_off_ph2: assert property (p_mux_off_ph2) else $error("mux held past phase two");
	property p_phases;
		second_phase_pulse |-> ##2 third_phase_pulse;
	endproperty
	a_phases: assert property (p_phases) else $error("phase three missing");
	property p_hold_read;
		data_hold_load |-> second_phase_pulse && $past(state_reg) == WCSA_READ;
	endproperty
	a_hold_read: assert property (p_hold_read) else $error("holder load mistimed");
	property p_trap;
		unused_opcode |=> microaddress == WCSA_PROM_BASE && trap_load &&
			trap_instr == $past(instr_word);
	endproperty
	a_trap: assert property (p_trap) else $error("opcode trap failed");
	property p_prom_range;
		prom_select |-> microaddress >= WCSA_PROM_BASE && microaddress < WCSA_PROM_LIMIT;
	endproperty
	a_prom_range: assert property (p_prom_range) else $error("prom out of range");
	property p_stack_addr;
		microaddress_select_mux |-> microaddress[WCSA_RAM_AW] ||
			microaddress == WCSA_PROM_BASE;
	endproperty
	a_stack_addr: assert property (p_stack_addr) else $error("stack address lost");
endmodule : wcsa_access

/* File: testbench/wcsa_seq_model.sv */
`timescale 1ns/10ps
module wcsa_seq_model
	import wcsa_pkg::*;
(
	input wire logic clk,
	output logic instr_start,
	output logic long_three_phase_cycle,
	output logic store_write_decoded,
	output logic store_read_decoded,
	output logic unused_opcode,
	output logic [WCSA_DATA_W-1:0] instr_word,
	output logic [WCSA_UADDR_W-1:0] next_address_lines,
	output logic [WCSA_DATA_W-1:0] stack_top,
	output logic [WCSA_DATA_W-1:0] processor_data_mux,
	output logic [WCSA_SHIFT_W-1:0] shift_count,
	output logic [WCSA_SHIFT_W-1:0] left_mask,
	output logic [WCSA_SHIFT_W-1:0] right_mask
);
	// quiet sequencer at time zero
	initial begin
		{instr_start, long_three_phase_cycle, store_write_decoded, store_read_decoded} = '0;
		{unused_opcode, instr_word, next_address_lines, stack_top} = '0;
		{processor_data_mux, shift_count, left_mask, right_mask} = '0;
	end

	// one microinstruction; kind 0 plain long, 1 write, 2 read; returns after take edge
	task automatic op(input int kind, input logic [15:0] s, input logic [15:0] d,
		input logic [3:0] a, input logic [3:0] b, input logic [3:0] c);
		@(negedge clk);
		long_three_phase_cycle = 1'b1;
		store_write_decoded = (kind == 1);
		store_read_decoded = (kind == 2);
		next_address_lines = WCSA_PROM_BASE + 11'h005;
		{stack_top, processor_data_mux} = {s, d};
		{shift_count, left_mask, right_mask} = {a, b, c};
		instr_start = 1'b1;
		@(posedge clk);
		@(negedge clk);
		instr_start = 1'b0;
	endtask : op

	// released lines turn over so stale values never look valid
	task automatic rel();
		{stack_top, processor_data_mux} = ~{stack_top, processor_data_mux};
		{long_three_phase_cycle, store_write_decoded, store_read_decoded} = '0;
	endtask : rel

	task automatic trap(input logic [15:0] w);
		@(negedge clk);
		{unused_opcode, instr_word} = {1'b1, w};
		@(posedge clk);
		@(negedge clk);
		{unused_opcode, instr_word} = {1'b0, ~w};
	endtask : trap

	task automatic idle(input logic [10:0] a);
		@(negedge clk);
		next_address_lines = a;
	endtask : idle
endmodule : wcsa_seq_model

/* File: testbench/tb.sv */
`timescale 1ns/10ps
module tb;
	import wcsa_pkg::*;
	logic clk, rst, instr_start, long_three_phase_cycle;
	logic store_write_decoded, store_read_decoded;
	logic unused_opcode, microaddress_select_mux, prom_select, ram_write_strobe;
	logic second_phase_pulse, third_phase_pulse, data_hold_load, trap_load;
	logic [15:0] instr_word, stack_top, processor_data_mux, reg_data_bus, trap_instr;
	logic [10:0] next_address_lines, microaddress;
	logic [3:0] shift_count, left_mask, right_mask;
	logic [79:0] ram_microword;
	logic [15:0] mem [1024][5];
	logic [15:0] wq[$];
	logic [15:0] s;
	logic [2:0] g;
	int failures = 0;
	int n_checks = 0;
	int seed = 26151;

	wcsa_access dut (.clk(clk), .rst(rst), .instr_start(instr_start),
		.long_three_phase_cycle(long_three_phase_cycle),
		.store_write_decoded(store_write_decoded), .store_read_decoded(store_read_decoded),
		.unused_opcode(unused_opcode),
		.instr_word(instr_word), .next_address_lines(next_address_lines),
		.stack_top(stack_top), .processor_data_mux(processor_data_mux),
		.shift_count(shift_count), .left_mask(left_mask), .right_mask(right_mask),
		.microaddress(microaddress), .microaddress_select_mux(microaddress_select_mux),
		.prom_select(prom_select), .ram_microword(ram_microword),
		.ram_write_strobe(ram_write_strobe), .second_phase_pulse(second_phase_pulse),
		.third_phase_pulse(third_phase_pulse), .reg_data_bus(reg_data_bus),
		.data_hold_load(data_hold_load), .trap_instr(trap_instr), .trap_load(trap_load));

	wcsa_seq_model seq (.clk(clk), .instr_start(instr_start),
		.long_three_phase_cycle(long_three_phase_cycle),
		.store_write_decoded(store_write_decoded), .store_read_decoded(store_read_decoded),
		.unused_opcode(unused_opcode),
		.instr_word(instr_word), .next_address_lines(next_address_lines),
		.stack_top(stack_top), .processor_data_mux(processor_data_mux),
		.shift_count(shift_count), .left_mask(left_mask), .right_mask(right_mask));

	task automatic chk(input string nm, input logic [79:0] e, input logic [79:0] v);
		n_checks++;
		if (v !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, e, v);
		end
	endtask : chk

	task automatic summarize();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : summarize

	// rotate right, then clear l bits at the top and r at the bottom
	function automatic logic [15:0] shm(input logic [15:0] v, input int sh, input int l,
		input int r);
		logic [15:0] x;
		x = (v >> sh) | (v << (16 - sh));
		for (int i = 0; i < 16; i++) begin
			if (i < r || i > 15 - l) x[i] = 1'b0;
		end
		return x;
	endfunction : shm

	// one store operation walked edge by edge against the reference memory
	task automatic run_op(input int kind, input logic [15:0] sa, input logic [15:0] d);
		logic [3:0] a, b, c;
		logic [2:0] gr;
		logic [15:0] e;
		a = 4'($random(seed));
		b = 4'($random(seed));
		c = 4'($random(seed));
		gr = {sa[14], sa[2:1]};
		if (kind == 1 && gr < 5) mem[sa[12:3]][gr] = d;
		e = (gr < 5) ? shm(mem[sa[12:3]][gr], a, b, c) : 16'h0000;
		seq.op(kind, sa, d, a, b, c);
		for (int n = 1; n < 8; n++) begin
			@(negedge clk);
			// n edges after the take edge; a dropped group write still strobes
			chk("write strobe", n == WCSA_WRITE_CYC - 1 && kind == 1, ram_write_strobe);
			chk("phase two", n == WCSA_PHASE2_CYC - 1, second_phase_pulse);
			chk("phase three", n == WCSA_LONG_CYC - 1, third_phase_pulse);
			chk("hold load", n == WCSA_PHASE2_CYC - 1 && kind == 2, data_hold_load);
			chk("addr mux", n < WCSA_PHASE2_CYC - 1 && kind != 0, microaddress_select_mux);
			if (kind != 0 && n == 1) chk("store addr", WCSA_RAM_BASE | sa[12:3], microaddress);
			if (kind != 0 && n < WCSA_PHASE2_CYC - 1) chk("prom off", 1'b0, prom_select);
			if (n >= WCSA_PHASE2_CYC - 1) chk("prom back", 1'b1, prom_select);
			if (kind == 2 && n == WCSA_PHASE2_CYC - 1) chk("read data", e, reg_data_bus);
		end
		seq.rel();
	endtask : run_op

	// idle fetch from a chosen microaddress
	task automatic fetch(input logic [10:0] a);
		seq.idle(a);
		@(negedge clk);
		chk("fetch addr", a, microaddress);
		chk("prom enable", a >= WCSA_PROM_BASE && a < WCSA_PROM_LIMIT, prom_select);
		@(negedge clk);
		if (a < WCSA_RAM_BASE) chk("rom area word", 80'h0, ram_microword);
	endtask : fetch

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// hang guard, far beyond the few hundred cycles the tests need
	initial begin
		#400000;
		failures++;
		summarize();
	end

	initial begin
		rst = 1'b1;
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		fetch(11'h0ff);
		fetch(11'h100);
		fetch(11'h1ff);
		fetch(11'h200);
		$display("test prom range done");
		// groups 0..4 at the top location, byte bit set to show it is ignored
		for (int k = 0; k < 5; k++) begin
			g = 3'(k);
			s = {1'b0, g[2], 1'b0, 10'h3ff, g[1:0], 1'b1};
			run_op(1, s, 16'($random(seed)));
			wq.push_back(s);
		end
		repeat (12) begin
			s = 16'($random(seed));
			run_op(1, s, 16'($random(seed)));
			if ({s[14], s[2:1]} < 5) wq.push_back(s);
		end
		run_op(1, 16'h5ffa, 16'hffff);
		run_op(0, 16'h0000, 16'h1234);
		$display("test writes done");
		run_op(2, 16'h5ffa, 16'h0000);
		foreach (wq[i]) run_op(2, wq[i], 16'($random(seed)));
		$display("test reads done");
		foreach (wq[i]) begin
			s = wq[i];
			g = {s[14], s[2:1]};
			fetch(WCSA_RAM_BASE | s[12:3]);
			chk("fetch slice", mem[s[12:3]][g], ram_microword[(g == 4 ? 64 : g * 16) +: 16]);
		end
		$display("test fetch done");
		s = 16'($random(seed));
		// trap state stands for the one cycle after the take edge
		seq.trap(s);
		chk("trap addr", WCSA_PROM_BASE, microaddress);
		chk("trap prom", 1'b1, prom_select);
		chk("trap load", 1'b1, trap_load);
		chk("trap word", s, trap_instr);
		@(negedge clk);
		chk("trap pulse", 1'b0, trap_load);
		$display("test trap done");
		summarize();
	end
endmodule : tb
